/* File: srap_consts.svh */
/*
 * constants of the serial register access port: word layout, register
 * map of the small local register file, reset values and pin timing.
 * assumes inclusion by its bare name from the package and the port module.
 */
`ifndef SRAP_CONSTS_SVH
`define SRAP_CONSTS_SVH

// word layout: address first, then data, msb first
`define SRAP_WORD_BITS      24
`define SRAP_ADDR_BITS      8
`define SRAP_DATA_BITS      16
`define SRAP_CNT_LAST       5'h17
`define SRAP_CNT_ZERO       5'h00
`define SRAP_CNT_ONE        5'h01
`define SRAP_CNT_ADDR_LAST  5'h07
`define SRAP_CNT_DATA_FIRST 5'h08

// local register file
`define SRAP_NUM_REGS       8
`define SRAP_IDX_BITS       3
`define SRAP_CTRL_ADDR      8'h00
`define SRAP_RDSEL_BIT      1
`define SRAP_SWRST_BIT      0
`define SRAP_REG_RESET      16'h0000
`define SRAP_ADDR_LIMIT     8'h08

// clock rate and reset timing
`define SRAP_CLK_PERIOD_NS  5
`define SRAP_RST_MIN_NS     100
`define SRAP_RST_CYCLES     ((`SRAP_RST_MIN_NS + `SRAP_CLK_PERIOD_NS - 1) \
                             / `SRAP_CLK_PERIOD_NS)

`endif

/* File: srap_pkg.sv */
/*
 * types shared by the serial register access port.
 * assumes srap_consts.svh is on the include path.
 */
`include "srap_consts.svh"

package srap_pkg;
    typedef logic [`SRAP_DATA_BITS-1:0] srap_word_t;
    typedef logic [`SRAP_ADDR_BITS-1:0] srap_addr_t;
    typedef logic [4:0]                 srap_cnt_t;
    typedef enum logic [1:0] {
        SRAP_IDLE  = 2'b00,
        SRAP_SHIFT = 2'b01
    } srap_state_t;
endpackage

/* File: srap_sync.sv */
/*
 * two flip-flop synchroniser for one pin level.
 * assumes the input is asynchronous to clk; reset value is a parameter.
 */
`timescale 1ns/100ps

module srap_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic pin,
    output logic      level
);
    logic meta_q;
    logic meta_d;
    logic level_q;
    logic level_d;

    // next values: first stage is read only by the second
    always_comb begin
        meta_d  = pin;
        level_d = meta_q;
    end

    // register the stages
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meta_q  <= RESET_VAL;
            level_q <= RESET_VAL;
        end else begin
            meta_q  <= meta_d;
            level_q <= level_d;
        end
    end

    assign level = level_q;
endmodule

/* File: srap_port.sv */
/*
 * serial register access port: 24-bit words of address and data shifted
 * in on serial clock rising edges while the enable is low, a small
 * register file, and readback on a shared three-state output.
 * assumes all serial pins are asynchronous to clk and that serial clock
 * phases last at least three clk periods.
 */
`timescale 1ns/100ps
`include "srap_consts.svh"

// Notes on behaviour
// - bits shift only while enable is low
// - sample data on each serial clock rise
// - load register on every 24th rise
// - drop trailing partial word bits
// - several words per enable, counter restarts
// - word is 8 address, 16 data
// - read cycle shifts addressed register out
// - readback bit stays writable, clear to write
// - output three-stated unless readback selected
module srap_port (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic serial_enable_n,
    input  wire logic serial_clk_pin,
    input  wire logic serial_in_pin,
    output logic      serial_out_pin,
    output logic      serial_out_oe,
    output logic [`SRAP_DATA_BITS-1:0] ctrl_word,
    output logic      readback_sel
);
    logic                  en_n_s;
    logic                  sclk_s;
    logic                  serial_in_pin_s;
    logic                  sclk_prev_q;
    logic                  sclk_prev_d;
    logic                  rise;
    logic                  fall;
    srap_pkg::srap_state_t state_q;
    srap_pkg::srap_state_t state_d;
    srap_pkg::srap_cnt_t   cnt_q;
    srap_pkg::srap_cnt_t   cnt_d;
    logic [`SRAP_WORD_BITS-2:0] shift_q;
    logic [`SRAP_WORD_BITS-2:0] shift_d;
    srap_pkg::srap_word_t  regs_q [`SRAP_NUM_REGS];
    srap_pkg::srap_word_t  regs_d [`SRAP_NUM_REGS];
    srap_pkg::srap_word_t  out_sr_q;
    srap_pkg::srap_word_t  out_sr_d;
    logic                  sdo_q;
    logic                  sdo_d;
    logic [`SRAP_WORD_BITS-1:0] word;
    srap_pkg::srap_addr_t  waddr;
    logic                  load;

    // register read with zero for unmapped addresses
    function automatic srap_pkg::srap_word_t reg_at(
        input srap_pkg::srap_word_t r [`SRAP_NUM_REGS],
        input srap_pkg::srap_addr_t a);
        if (a < `SRAP_ADDR_LIMIT)
            return r[a[`SRAP_IDX_BITS-1:0]];
        else
            return `SRAP_REG_RESET;
    endfunction

    // pins pass two flip-flops first; enable idles high
    srap_sync #(.RESET_VAL(1'b1)) u_sync_en (
        .clk     (clk),
        .reset_n (reset_n),
        .pin     (serial_enable_n),
        .level   (en_n_s)
    );
    srap_sync #(.RESET_VAL(1'b0)) u_sync_sclk (
        .clk     (clk),
        .reset_n (reset_n),
        .pin     (serial_clk_pin),
        .level   (sclk_s)
    );
    srap_sync #(.RESET_VAL(1'b0)) u_sync_serial_in_pin (
        .clk     (clk),
        .reset_n (reset_n),
        .pin     (serial_in_pin),
        .level   (serial_in_pin_s)
    );

    // serial clock edge detection on the synchronised level
    assign rise  = sclk_s & ~sclk_prev_q;
    assign fall  = ~sclk_s & sclk_prev_q;
    assign word  = {shift_q, serial_in_pin_s};
    assign waddr = word[`SRAP_WORD_BITS-1:`SRAP_DATA_BITS];
    assign load  = (state_q == srap_pkg::SRAP_SHIFT) && rise
                   && !en_n_s && (cnt_q == `SRAP_CNT_LAST);

    // next state of the shifter, counter and register file
    always_comb begin
        sclk_prev_d = sclk_s;
        state_d     = state_q;
        cnt_d       = cnt_q;
        shift_d     = shift_q;
        regs_d      = regs_q;
        out_sr_d    = out_sr_q;
        sdo_d       = sdo_q;
        if (en_n_s) begin
            // enable high: no shifting, partial word dropped
            state_d = srap_pkg::SRAP_IDLE;
            cnt_d   = `SRAP_CNT_ZERO;
        end else if (state_q == srap_pkg::SRAP_IDLE) begin
            // enable falling edge restarts the group counter
            state_d = srap_pkg::SRAP_SHIFT;
            cnt_d   = `SRAP_CNT_ZERO;
            if (rise) begin
                shift_d = {shift_q[`SRAP_WORD_BITS-3:0], serial_in_pin_s};
                cnt_d   = `SRAP_CNT_ONE;
            end
        end else if (rise) begin
            shift_d = {shift_q[`SRAP_WORD_BITS-3:0], serial_in_pin_s};
            if (cnt_q == `SRAP_CNT_LAST) begin
                cnt_d = `SRAP_CNT_ZERO;
            end else begin
                cnt_d = srap_pkg::srap_cnt_t'(cnt_q + `SRAP_CNT_ONE);
            end
            // address complete after the eighth bit: load readback data
            if (cnt_q == `SRAP_CNT_ADDR_LAST) begin
                out_sr_d = reg_at(regs_q, word[`SRAP_ADDR_BITS-1:0]);
            end
        end
        // output bit changes on the serial clock fall, msb first
        if (fall && !en_n_s && state_q == srap_pkg::SRAP_SHIFT
            && cnt_q >= `SRAP_CNT_DATA_FIRST) begin
            sdo_d    = out_sr_q[`SRAP_DATA_BITS-1];
            out_sr_d = {out_sr_q[`SRAP_DATA_BITS-2:0], 1'b0};
        end
        if (load) begin
            if (waddr == `SRAP_CTRL_ADDR) begin
                // control stays writable even in readback
                regs_d[0] = word[`SRAP_DATA_BITS-1:0];
                if (word[`SRAP_SWRST_BIT]) begin
                    for (int i = 0; i < `SRAP_NUM_REGS; i++) begin
                        regs_d[i] = `SRAP_REG_RESET;
                    end
                end
            end else if (!regs_q[0][`SRAP_RDSEL_BIT]
                         && waddr < `SRAP_ADDR_LIMIT) begin
                regs_d[waddr[`SRAP_IDX_BITS-1:0]] =
                    word[`SRAP_DATA_BITS-1:0];
            end
        end
    end

    // register all state; reset clears counter and registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sclk_prev_q <= 1'b0;
            state_q     <= srap_pkg::SRAP_IDLE;
            cnt_q       <= `SRAP_CNT_ZERO;
            shift_q     <= '0;
            out_sr_q    <= `SRAP_REG_RESET;
            sdo_q       <= 1'b0;
            for (int i = 0; i < `SRAP_NUM_REGS; i++) begin
                regs_q[i] <= `SRAP_REG_RESET;
            end
        end else begin
            sclk_prev_q <= sclk_prev_d;
            state_q     <= state_d;
            cnt_q       <= cnt_d;
            shift_q     <= shift_d;
            out_sr_q    <= out_sr_d;
            sdo_q       <= sdo_d;
            regs_q      <= regs_d;
        end
    end

    // outputs; driver enabled only while readback is selected
    assign readback_sel   = regs_q[0][`SRAP_RDSEL_BIT];
    assign serial_out_oe  = regs_q[0][`SRAP_RDSEL_BIT];
    assign serial_out_pin = sdo_q;
    assign ctrl_word      = regs_q[0];

    // no word is loaded while the enable is high
    property p_no_load_idle;
        @(posedge clk) disable iff (!reset_n)
        en_n_s |=> $stable(regs_q[1]) && $stable(regs_q[0]);
    endproperty
    a_no_load_idle: assert property (p_no_load_idle)
        else $error("register changed with enable high");

    // counter advances only on a serial clock rise
    property p_count_on_rise;
        @(posedge clk) disable iff (!reset_n)
        (!en_n_s && state_q == srap_pkg::SRAP_SHIFT && !rise)
            |=> cnt_q == $past(cnt_q);
    endproperty
    a_count_on_rise: assert property (p_count_on_rise)
        else $error("bit counter moved without a clock rise");

    // a completed word to control lands one cycle later
    property p_load_ctrl;
        @(posedge clk) disable iff (!reset_n)
        (load && waddr == `SRAP_CTRL_ADDR && !word[`SRAP_SWRST_BIT])
            |=> regs_q[0] == $past(word[`SRAP_DATA_BITS-1:0]);
    endproperty
    a_load_ctrl: assert property (p_load_ctrl)
        else $error("control word not loaded on 24th bit");

    // enable rising resets counter
    property p_drop_partial;
        @(posedge clk) disable iff (!reset_n)
        en_n_s |=> cnt_q == `SRAP_CNT_ZERO;
    endproperty
    a_drop_partial: assert property (p_drop_partial)
        else $error("partial word count kept");

    // counter wraps after the last bit of a word
    property p_wrap;
        @(posedge clk) disable iff (!reset_n)
        load |=> cnt_q == `SRAP_CNT_ZERO;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("group counter failed to wrap");

    // readback blocks writes to other registers
    property p_rd_blocks;
        @(posedge clk) disable iff (!reset_n)
        (load && readback_sel && waddr != `SRAP_CTRL_ADDR)
            |=> $stable(regs_q[1]) && $stable(regs_q[2])
                && $stable(regs_q[3]) && $stable(regs_q[4])
                && $stable(regs_q[5]) && $stable(regs_q[6])
                && $stable(regs_q[7]);
    endproperty
    a_rd_blocks: assert property (p_rd_blocks)
        else $error("write taken during readback");

    // output enable only comes up through a control write
    property p_oe;
        @(posedge clk) disable iff (!reset_n)
        (!serial_out_oe && !(load && waddr == `SRAP_CTRL_ADDR
                             && word[`SRAP_RDSEL_BIT]))
            |=> !serial_out_oe;
    endproperty
    a_oe: assert property (p_oe)
        else $error("output driven outside readback");

    // eighth rise of a word: address byte complete
    sequence s_addr_done;
        rise && !en_n_s && state_q == srap_pkg::SRAP_SHIFT
            && cnt_q == `SRAP_CNT_ADDR_LAST;
    endsequence

    // address byte names the control register
    sequence s_addr_ctrl;
        word[`SRAP_ADDR_BITS-1:0] == `SRAP_CTRL_ADDR;
    endsequence

    // readback shifter takes the control register when that is addressed
    property p_rd_load;
        @(posedge clk) disable iff (!reset_n)
        s_addr_done ##0 s_addr_ctrl |=> out_sr_q == $past(regs_q[0]);
    endproperty
    a_rd_load: assert property (p_rd_load)
        else $error("readback data not loaded after address");

    // after reset, counter and control register are cleared
    property p_reset;
        @(posedge clk)
        !reset_n |=> cnt_q == `SRAP_CNT_ZERO && regs_q[0] == `SRAP_REG_RESET
                     && !serial_out_oe;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset left state behind");
endmodule

/* File: srap_ctrl_model.sv */
/*
 * external controller model: frames, words and bytes on the serial pins.
 * assumes its serial clock runs at 125 ns and stands low between bytes.
 */
`timescale 1ns/100ps

module srap_ctrl_model (
    output logic      serial_enable_n,
    output logic      serial_clk_pin,
    output logic      serial_in_pin,
    input  wire logic serial_out_pin,
    input  wire logic serial_out_oe
);
    // idle pins at their pull levels
    initial begin
        serial_enable_n = 1'b1;
        serial_clk_pin  = 1'b0;
        serial_in_pin   = 1'b0;
    end

    // enable low opens a frame
    task automatic open_frame();
        #62.5 serial_enable_n = 1'b0;
    endtask

    // data line falls to its pull-down once released
    task automatic close_frame();
        #62.5 serial_enable_n = 1'b1;
        serial_in_pin = 1'b0;
    endtask

    // eight bits msb first, output captured on each rise
    task automatic shift8(input logic [7:0] b, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) begin
            serial_in_pin = b[i];
            #62.5 serial_clk_pin = 1'b1;
            q[i] = serial_out_oe ? serial_out_pin : ~serial_out_pin;
            #62.5 serial_clk_pin = 1'b0;
        end
    endtask

    // one word: address byte then two data bytes
    task automatic word(input logic [23:0] w, output logic [15:0] rd);
        logic [7:0] q;
        shift8(w[23:16], q);
        shift8(w[15:8], q);
        rd[15:8] = q;
        shift8(w[7:0], q);
        rd[7:0] = q;
    endtask
endmodule

/* File: srap_port_bench.sv */
/*
 * bench of the serial register access port: one task per scenario.
 * assumes srap_ctrl_model drives the serial pins as the controller.
 */
`timescale 1ns/100ps

module srap_port_bench;
    logic        clk, reset_n, serial_enable_n, serial_clk_pin;
    logic        serial_in_pin, serial_out_pin, serial_out_oe;
    logic        readback_sel;
    logic [15:0] ctrl_word, rd;
    logic [7:0]  q;
    int          num_errors = 0;
    int          checks = 0;

    srap_port i_dut (
        .clk(clk), .reset_n(reset_n), .serial_enable_n(serial_enable_n),
        .serial_clk_pin(serial_clk_pin), .serial_in_pin(serial_in_pin),
        .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
        .ctrl_word(ctrl_word), .readback_sel(readback_sel));

    srap_ctrl_model i_ctrl (
        .serial_enable_n(serial_enable_n), .serial_clk_pin(serial_clk_pin),
        .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
        .serial_out_oe(serial_out_oe));

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk16(input string n, input logic [15:0] e,
                         input logic [15:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk1(input string n, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %b seen %b", n, e, g);
        end
    endtask

    // one whole frame holding one word, read data kept in rd
    task automatic xfer(input logic [7:0] a, input logic [15:0] d);
        i_ctrl.open_frame();
        i_ctrl.word({a, d}, rd);
        i_ctrl.close_frame();
    endtask

    task automatic hw_reset();
        @(posedge clk);
        #1 reset_n = 1'b0;
        repeat (12) @(posedge clk);
        #1 reset_n = 1'b1;
        repeat (20) @(posedge clk);
        #1;
    endtask

    task automatic t_idle();
        chk16("ctrl_word", 16'h0000, ctrl_word);
        chk1("readback_sel", 1'b0, readback_sel);
        chk1("serial_out_oe", 1'b0, serial_out_oe);
    endtask

    // two words in one frame, each lands at its own 24th rise
    task automatic t_multi();
        i_ctrl.open_frame();
        i_ctrl.word({8'h00, 16'hA5A4}, rd);
        #62.5 chk16("ctrl_word", 16'hA5A4, ctrl_word);
        i_ctrl.word({8'h00, 16'h5A58}, rd);
        i_ctrl.close_frame();
        chk16("ctrl_word", 16'h5A58, ctrl_word);
    endtask

    // trailing bits dropped, short frame changes nothing
    task automatic t_partial();
        i_ctrl.open_frame();
        i_ctrl.word({8'h00, 16'h1230}, rd);
        i_ctrl.shift8(8'hFF, q);
        i_ctrl.close_frame();
        chk16("ctrl_word", 16'h1230, ctrl_word);
        i_ctrl.open_frame();
        i_ctrl.shift8(8'h00, q);
        i_ctrl.shift8(8'h77, q);
        i_ctrl.close_frame();
        chk16("ctrl_word", 16'h1230, ctrl_word);
        i_ctrl.shift8(8'hFF, q); // clock runs with enable high
        xfer(8'h00, 16'h4568);
        chk16("ctrl_word", 16'h4568, ctrl_word);
    endtask

    // readback of a register, writes blocked until the bit clears
    task automatic t_readback();
        xfer(8'h03, 16'hC3A5);
        xfer(8'h00, 16'h0002);
        chk1("readback_sel", 1'b1, readback_sel);
        chk1("serial_out_oe", 1'b1, serial_out_oe);
        xfer(8'h03, 16'h0000);
        chk16("read reg3", 16'hC3A5, rd);
        xfer(8'h03, 16'h1111);
        xfer(8'h03, 16'h0000);
        chk16("read reg3", 16'hC3A5, rd);
        xfer(8'h08, 16'h0000);
        chk16("read unmapped", 16'h0000, rd);
        xfer(8'h00, 16'h0000);
        chk16("read reg0", 16'h0002, rd);
        chk1("readback_sel", 1'b0, readback_sel);
        chk1("serial_out_oe", 1'b0, serial_out_oe);
    endtask

    // serial soft reset, then a hardware reset in mid-run
    task automatic t_resets();
        xfer(8'h00, 16'h00F0);
        xfer(8'h00, 16'h0001);
        chk16("ctrl_word", 16'h0000, ctrl_word);
        xfer(8'h00, 16'h0002);
        xfer(8'h03, 16'h0000);
        chk16("read reg3", 16'h0000, rd);
        xfer(8'h00, 16'h00F2);
        chk16("ctrl_word", 16'h00F2, ctrl_word);
        hw_reset();
        t_idle();
    endtask

    task automatic print_verdict();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        reset_n = 1'b0;
        repeat (12) @(posedge clk);
        #1 reset_n = 1'b1;
        repeat (20) @(posedge clk);
        #1;
        t_idle();
        t_multi();
        t_partial();
        t_readback();
        t_resets();
        print_verdict();
    end

    // watchdog well beyond the expected run
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        print_verdict();
    end
endmodule
